// File: rtl/rcic_top.sv
`timescale 1ns/1ps
`include "rcic_defs.svh"
module rcic_top (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_ce,
    input  wire logic       i_power_on,
    input  wire logic       i_reset_pin_b,
    input  wire logic       i_wdog_expire,
    input  wire logic       i_timer_ovf,
    input  wire logic [7:0] i_port,
    input  wire logic [7:0] i_port_is_out,
    input  wire logic       i_bit0_is_ext,
    input  wire logic       i_port_read,
    input  wire logic       i_global_irq_on_instr,
    input  wire logic       i_global_irq_off_instr,
    input  wire logic       i_return_from_irq_instr,
    input  wire logic       i_sleep_instr,
    input  wire logic       i_watchdog_clear_instr,
    input  wire logic       i_soft_irq_instr,
    input  wire logic       i_vector_taken,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_sel_mask,
    input  wire logic [3:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_irq_flag_reg,
    output logic      [7:0] o_irq_mask_reg,
    output logic      [7:0] o_cpu_status_bits,
    output logic            o_core_reset,
    output logic            o_sleeping,
    output logic            o_wake,
    output logic            o_vector_req,
    output logic      [7:0] o_vector_addr,
    output logic            o_global_en
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [7:0] port_s;
    logic [3:0] misc_s;
    logic       pin_s;
    logic       wdog_s;
    logic       tmr_s;
    logic       ext_s;

    rcic_sync #(.W(8)) u_port_sync (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_ce    (i_ce),
        .i_d     (i_port),
        .o_q     (port_s)
    );

    rcic_sync #(.W(4)) u_misc_sync (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_ce    (i_ce),
        .i_d     ({i_reset_pin_b, ~i_wdog_expire, ~i_timer_ovf, i_port[0]}),
        .o_q     (misc_s)
    );

    assign pin_s  = misc_s[3];
    assign wdog_s = ~misc_s[2];
    assign tmr_s  = ~misc_s[1];
    assign ext_s  = misc_s[0];

    // ------------------------------------------------------------
    // edge history and status state
    // ------------------------------------------------------------
    logic                  pin_d_ff,    nxt_pin_d;
    logic                  pin_low_ff,  nxt_pin_low;
    logic                  wdog_d_ff,   nxt_wdog_d;
    logic                  tmr_d_ff,    nxt_tmr_d;
    logic                  ext_d_ff,    nxt_ext_d;
    logic                  chg_d_ff,    nxt_chg_d;
    logic                  to_ff,       nxt_to;
    logic                  pd_ff,       nxt_pd;
    logic                  rst_ff,      nxt_rst;
    logic                  po_done_ff,  nxt_po_done;
    rcic_pkg::rcic_pwr_t   pwr_ff,      nxt_pwr;
    logic [2:0]            flag_ff,     nxt_flag;
    logic [2:0]            mask_ff,     nxt_mask;
    logic                  gie_ff,      nxt_gie;
    logic                  vreq_ff,     nxt_vreq;
    logic [7:0]            vaddr_ff,    nxt_vaddr;
    logic                  wake_ff,     nxt_wake;
    logic                  change;
    logic                  pin_pulse;
    logic                  wdog_ev;
    logic [2:0]            ev;
    logic [2:0]            pend;
    rcic_pkg::rcic_rst_src_t src;

    rcic_chg_det u_chg (
        .i_clk         (i_clk),
        .i_rst_b       (i_rst_b),
        .i_ce          (i_ce),
        .i_port        (port_s),
        .i_port_is_out (i_port_is_out),
        .i_bit0_is_ext (i_bit0_is_ext),
        .i_port_read   (i_port_read),
        .o_change      (change)
    );

    function automatic logic fall(input logic prev, input logic cur);
        fall = prev & ~cur;
    endfunction : fall

    function automatic logic rise(input logic prev, input logic cur);
        rise = ~prev & cur;
    endfunction : rise

    always_comb begin
        nxt_pin_d   = pin_s;
        nxt_wdog_d  = wdog_s;
        nxt_tmr_d   = tmr_s;
        nxt_ext_d   = ext_s;
        nxt_chg_d   = change;
        nxt_pin_low = pin_low_ff;
        if (fall(pin_d_ff, pin_s)) begin
            nxt_pin_low = 1'b1;
        end
        // R1 pin reset on high-low-high
        pin_pulse = pin_low_ff & rise(pin_d_ff, pin_s);
        if (pin_pulse) begin
            nxt_pin_low = 1'b0;
        end
        wdog_ev = rise(wdog_d_ff, wdog_s);
        // R9 edge sources: timer and pin falling, change rising
        ev[`RCIC_BIT_TIMER]  = fall(tmr_d_ff, tmr_s);
        ev[`RCIC_BIT_CHANGE] = rise(chg_d_ff, change);
        ev[`RCIC_BIT_EXTPIN] = i_bit0_is_ext & fall(ext_d_ff, ext_s);
        // R1 reset source select
        if (!po_done_ff || i_power_on) begin
            src = rcic_pkg::RCIC_RST_POWER;
        end else if (pin_pulse) begin
            src = rcic_pkg::RCIC_RST_PIN;
        end else if (wdog_ev) begin
            src = rcic_pkg::RCIC_RST_WDOG;
        end else begin
            src = rcic_pkg::RCIC_RST_NONE;
        end
    end

    // ------------------------------------------------------------
    // reset cause and power state
    // ------------------------------------------------------------
    always_comb begin
        nxt_to      = to_ff;
        nxt_pd      = pd_ff;
        nxt_pwr     = pwr_ff;
        nxt_rst     = 1'b0;
        nxt_wake    = 1'b0;
        nxt_po_done = 1'b1;
        case (src)
            rcic_pkg::RCIC_RST_POWER: begin
                // R2 both read 1
                nxt_to  = 1'b1;
                nxt_pd  = 1'b1;
                nxt_rst = 1'b1;
                nxt_pwr = rcic_pkg::RCIC_RUN;
            end
            rcic_pkg::RCIC_RST_PIN: begin
                nxt_rst = 1'b1;
                if (pwr_ff == rcic_pkg::RCIC_SLEEP) begin
                    // R4 pin wake from sleep
                    nxt_to   = 1'b1;
                    nxt_pd   = 1'b0;
                    nxt_wake = 1'b1;
                end
                // R3 running pin reset keeps flags
                nxt_pwr = rcic_pkg::RCIC_RUN;
            end
            rcic_pkg::RCIC_RST_WDOG: begin
                nxt_rst = 1'b1;
                // R5 R8 watchdog clears timeout
                nxt_to  = 1'b0;
                if (pwr_ff == rcic_pkg::RCIC_SLEEP) begin
                    // R6 sleep wake clears both
                    nxt_pd   = 1'b0;
                    nxt_wake = 1'b1;
                end
                nxt_pwr = rcic_pkg::RCIC_RUN;
            end
            default: begin
                // R8 instruction effects on status
                if (i_ce && i_watchdog_clear_instr) begin
                    nxt_to = 1'b1;
                    nxt_pd = 1'b1;
                end else if (i_ce && i_sleep_instr) begin
                    nxt_to  = 1'b1;
                    nxt_pd  = 1'b0;
                    nxt_pwr = rcic_pkg::RCIC_SLEEP;
                end
                // R7 R12 input-change wake
                if (pwr_ff == rcic_pkg::RCIC_SLEEP && ev[`RCIC_BIT_CHANGE] && mask_ff[`RCIC_BIT_CHANGE]) begin
                    nxt_to   = 1'b1;
                    nxt_pd   = 1'b0;
                    nxt_pwr  = rcic_pkg::RCIC_RUN;
                    nxt_wake = 1'b1;
                end
            end
        endcase
        if (!i_ce) begin
            nxt_to      = to_ff;
            nxt_pd      = pd_ff;
            nxt_pwr     = pwr_ff;
            nxt_rst     = rst_ff;
            nxt_wake    = wake_ff;
            nxt_po_done = po_done_ff;
        end
    end

    // ------------------------------------------------------------
    // interrupt flags, mask, global enable, vectoring
    // ------------------------------------------------------------
    always_comb begin
        nxt_flag  = flag_ff;
        nxt_mask  = mask_ff;
        nxt_gie   = gie_ff;
        nxt_vreq  = 1'b0;
        nxt_vaddr = vaddr_ff;
        // R22 software write of 0 clears a flag
        if (i_reg_wr && !i_reg_sel_mask && i_reg_addr == `RCIC_FLAG_ADDR) begin
            nxt_flag = flag_ff & i_reg_wdata[2:0];
        end
        if (i_reg_wr && i_reg_sel_mask && i_reg_addr == `RCIC_MASK_ADDR) begin
            nxt_mask = i_reg_wdata[2:0];
        end
        // R17 timer and pin flags set regardless of mask; set wins over a software clear, a reset source wins over set
        nxt_flag[`RCIC_BIT_TIMER]  = nxt_flag[`RCIC_BIT_TIMER]  | ev[`RCIC_BIT_TIMER];
        nxt_flag[`RCIC_BIT_EXTPIN] = nxt_flag[`RCIC_BIT_EXTPIN] | ev[`RCIC_BIT_EXTPIN];
        // R17 change flag only when enabled
        nxt_flag[`RCIC_BIT_CHANGE] = nxt_flag[`RCIC_BIT_CHANGE] | (ev[`RCIC_BIT_CHANGE] & mask_ff[`RCIC_BIT_CHANGE]);
        // R14 R19 enable and disable instructions
        if (i_global_irq_on_instr || i_return_from_irq_instr) begin
            nxt_gie = 1'b1;
        end else if (i_global_irq_off_instr) begin
            nxt_gie = 1'b0;
        end
        // R20 software interrupt vector
        if (gie_ff && i_soft_irq_instr) begin
            nxt_vreq  = 1'b1;
            nxt_vaddr = `RCIC_VEC_SOFT;
        // R15 R12 vector to 008H
        end else if (gie_ff && |pend && pwr_ff == rcic_pkg::RCIC_RUN) begin
            nxt_vreq  = 1'b1;
            nxt_vaddr = `RCIC_VEC_IRQ;
        end
        // R23 no nesting after vectoring
        if (i_vector_taken) begin
            nxt_gie = 1'b0;
        end
        if (src != rcic_pkg::RCIC_RST_NONE) begin
            nxt_flag  = `RCIC_FLAG_RST;
            nxt_mask  = `RCIC_MASK_RST;
            nxt_gie   = 1'b0;
            nxt_vreq  = 1'b0;
        end
        if (!i_ce) begin
            nxt_flag  = flag_ff;
            nxt_mask  = mask_ff;
            nxt_gie   = gie_ff;
            nxt_vreq  = vreq_ff;
            nxt_vaddr = vaddr_ff;
        end
    end

    // R18 request is flag AND mask
    assign pend = flag_ff & mask_ff;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_d_ff   <= 1'b1;
            pin_low_ff <= 1'b0;
            wdog_d_ff  <= 1'b0;
            // idle level of the synced overflow line, so no false fall after reset
            tmr_d_ff   <= 1'b0;
            ext_d_ff   <= 1'b1;
            chg_d_ff   <= 1'b0;
            to_ff      <= 1'b1;
            pd_ff      <= 1'b1;
            rst_ff     <= 1'b1;
            po_done_ff <= 1'b0;
            pwr_ff     <= rcic_pkg::RCIC_RUN;
            flag_ff    <= `RCIC_FLAG_RST;
            mask_ff    <= `RCIC_MASK_RST;
            gie_ff     <= 1'b0;
            vreq_ff    <= 1'b0;
            vaddr_ff   <= 8'h00;
            wake_ff    <= 1'b0;
        end else if (i_ce) begin
            pin_d_ff   <= nxt_pin_d;
            pin_low_ff <= nxt_pin_low;
            wdog_d_ff  <= nxt_wdog_d;
            tmr_d_ff   <= nxt_tmr_d;
            ext_d_ff   <= nxt_ext_d;
            chg_d_ff   <= nxt_chg_d;
            to_ff      <= nxt_to;
            pd_ff      <= nxt_pd;
            rst_ff     <= nxt_rst;
            po_done_ff <= nxt_po_done;
            pwr_ff     <= nxt_pwr;
            flag_ff    <= nxt_flag;
            mask_ff    <= nxt_mask;
            gie_ff     <= nxt_gie;
            vreq_ff    <= nxt_vreq;
            vaddr_ff   <= nxt_vaddr;
            wake_ff    <= nxt_wake;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        o_cpu_status_bits                = 8'h00;
        // R21 status bit positions
        o_cpu_status_bits[`RCIC_BIT_TO]  = to_ff;
        o_cpu_status_bits[`RCIC_BIT_PD]  = pd_ff;
    end

    // R13 separate flag and mask registers
    assign o_irq_flag_reg = {5'h00, flag_ff};
    assign o_irq_mask_reg = {5'h00, mask_ff};
    assign o_core_reset   = rst_ff;
    assign o_sleeping     = (pwr_ff == rcic_pkg::RCIC_SLEEP);
    assign o_wake         = wake_ff;
    assign o_vector_req   = vreq_ff;
    assign o_vector_addr  = vaddr_ff;
    assign o_global_en    = gie_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_poweron_flags;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && i_power_on) |=> (to_ff && pd_ff && rst_ff);
    endproperty
    a_poweron_flags: assert property (p_poweron_flags) else $error("power-on flags wrong"); // R2

    property p_and_req;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && po_done_ff && !i_power_on && gie_ff && |pend && pwr_ff == rcic_pkg::RCIC_RUN
         && !i_soft_irq_instr && src == rcic_pkg::RCIC_RST_NONE)
        |=> (vreq_ff && vaddr_ff == 8'h08);
    endproperty
    a_and_req: assert property (p_and_req) else $error("vector 008H not requested"); // R15

    property p_soft;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && gie_ff && i_soft_irq_instr && src == rcic_pkg::RCIC_RST_NONE) |=> (vaddr_ff == 8'h01);
    endproperty
    a_soft: assert property (p_soft) else $error("soft vector not 001H"); // R20

    property p_no_gie_no_vec;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && !gie_ff) |=> !vreq_ff;
    endproperty
    a_no_gie_no_vec: assert property (p_no_gie_no_vec) else $error("vector without enable"); // R15

    property p_sleep_instr;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && i_sleep_instr && !i_watchdog_clear_instr && src == rcic_pkg::RCIC_RST_NONE)
        |=> (to_ff && !pd_ff);
    endproperty
    a_sleep_instr: assert property (p_sleep_instr) else $error("sleep flags wrong"); // R8

    property p_wdog_to;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && src == rcic_pkg::RCIC_RST_WDOG) |=> (!to_ff && rst_ff);
    endproperty
    a_wdog_to: assert property (p_wdog_to) else $error("watchdog kept timeout"); // R5

    property p_pin_keep;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && src == rcic_pkg::RCIC_RST_PIN && pwr_ff == rcic_pkg::RCIC_RUN)
        |=> (to_ff == $past(to_ff) && pd_ff == $past(pd_ff));
    endproperty
    a_pin_keep: assert property (p_pin_keep) else $error("pin reset changed flags"); // R3

    property p_timer_flag;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && ev[0] && src == rcic_pkg::RCIC_RST_NONE) |=> flag_ff[0];
    endproperty
    a_timer_flag: assert property (p_timer_flag) else $error("timer flag not set"); // R17

    property p_vec_clears_gie;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && i_vector_taken) |=> !gie_ff;
    endproperty
    a_vec_clears_gie: assert property (p_vec_clears_gie) else $error("enable kept after vector"); // R23
endmodule : rcic_top

// File: rtl/rcic_defs.svh
`ifndef RCIC_DEFS_SVH
`define RCIC_DEFS_SVH
// Functional notes
// R1 - reset entered on power-on, reset-pin pulse, or watchdog expiry.
// R2 - after power-on timeout and power-down flags both read 1.
// R3 - pin reset while running keeps both status flags.
// R4 - pin wake from sleep sets timeout, clears power-down.
// R5 - watchdog reset while running clears timeout, keeps power-down.
// R6 - watchdog wake from sleep clears both status flags.
// R7 - input-change wake from sleep sets timeout, clears power-down.
// R8 - watchdog-clear sets both; sleep sets timeout clears power-down; timeout clears timeout.
// R9 - three falling-edge sources: timer overflow, input change, external pin; the code takes input change on its rising edge.
// R10 - software reads the port once before enabling change interrupt.
// R11 - change detector ignores output pins and bit 0 when used as external pin.
// R12 - enabled input change wakes; continue or vector 008H per global enable.
// R13 - each request has its own flag bit; separate per-source mask.
// R14 - enable instruction sets global enable; disable instruction clears it.
// R15 - unmasked interrupt with global enable fetches from 008H.
// R16 - service routine clears the flag before return and re-enable.
// R17 - timer and pin flags set regardless of mask; change flag excepted.
// R18 - request to core is flag AND mask.
// R19 - return-from-interrupt ends service and sets global enable.
// R20 - software interrupt while enabled fetches from 001H.
// R21 - timeout flag at status bit 4, power-down flag at bit 3.
// R22 - flag and mask bits: pin 2, change 1, timer 0; write 0 clears.
// R23 - vectoring clears global enable until return or enable instruction.

`define RCIC_FLAG_ADDR   4'hF
`define RCIC_MASK_ADDR   4'hF
`define RCIC_BIT_TIMER   0
`define RCIC_BIT_CHANGE  1
`define RCIC_BIT_EXTPIN  2
`define RCIC_BIT_PD      3
`define RCIC_BIT_TO      4
`define RCIC_IRQ_MASK3   3'h7
`define RCIC_VEC_IRQ     8'h08
`define RCIC_VEC_SOFT    8'h01
`define RCIC_FLAG_RST    3'h0
`define RCIC_MASK_RST    3'h0
`endif

// File: rtl/rcic_pkg.sv
package rcic_pkg;
    typedef enum logic [2:0] {
        RCIC_RST_NONE,
        RCIC_RST_POWER,
        RCIC_RST_PIN,
        RCIC_RST_WDOG
    } rcic_rst_src_t;
    typedef enum logic [1:0] {
        RCIC_RUN,
        RCIC_SLEEP
    } rcic_pwr_t;
endpackage : rcic_pkg

// File: rtl/rcic_sync.sv
`timescale 1ns/1ps
module rcic_sync #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    always_comb begin
        nxt_meta = i_ce ? i_d : meta_ff;
        nxt_q    = i_ce ? meta_ff : q_ff;
    end

    // constant reset value: no port value under async reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_ff <= '1;
            q_ff    <= '1;
        end else begin
            meta_ff <= nxt_meta;
            q_ff    <= nxt_q;
        end
    end

    assign o_q = q_ff;
endmodule : rcic_sync

// File: rtl/rcic_chg_det.sv
`timescale 1ns/1ps
module rcic_chg_det (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_ce,
    input  wire logic [7:0] i_port,
    input  wire logic [7:0] i_port_is_out,
    input  wire logic       i_bit0_is_ext,
    input  wire logic       i_port_read,
    output logic            o_change
);
    logic [7:0] ref_ff;
    logic [7:0] nxt_ref;
    logic [7:0] watch;

    always_comb begin
        // R11 ignore outputs and shared bit 0
        watch    = ~i_port_is_out;
        watch[0] = watch[0] & ~i_bit0_is_ext;
        // R10 reference refreshed by a port read
        nxt_ref  = (i_ce && i_port_read) ? i_port : ref_ff;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ref_ff <= 8'hFF;
        end else begin
            ref_ff <= nxt_ref;
        end
    end

    assign o_change = |((i_port ^ ref_ff) & watch);
endmodule : rcic_chg_det

// File: tb/rcic_core_model.sv
`timescale 1ns/1ps
module rcic_core_model (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_vector_req,
    input  wire logic i_slow,
    output logic      o_vector_taken
);
    logic [2:0] wait_ff;

    // ----------------------------------------
    // vector acceptance by the sequencer
    // ----------------------------------------
    // fetch is redirected, then accepted once
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wait_ff        <= 3'h0;
            o_vector_taken <= 1'b0;
        end else begin
            o_vector_taken <= (wait_ff == 3'h1);
            if (wait_ff != 3'h0) begin
                wait_ff <= wait_ff - 3'h1;
            end else if (i_vector_req) begin
                // slow core leaves the request pending longer
                wait_ff <= i_slow ? 3'h4 : 3'h1;
            end
        end
    end
endmodule : rcic_core_model

// File: tb/rcic_top_tb.sv
`timescale 1ns/1ps
module rcic_top_tb;
    logic       i_clk;
    logic       i_rst_b;
    logic       ce;
    logic [2:0] ev;
    logic       tovf;
    logic [7:0] port;
    logic [7:0] is_out;
    logic       b0ext;
    logic       pread;
    logic [5:0] instr;
    logic       reg_wr;
    logic       sel;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       slow;
    logic       vtaken;
    logic [7:0] flag;
    logic [7:0] mask;
    logic [7:0] stat;
    logic [7:0] vaddr;
    logic       core_rst;
    logic       sleeping;
    logic       wake;
    logic       vreq;
    logic       gie;
    logic [7:0] vec_cnt;
    logic [7:0] vec_last;
    logic [7:0] wake_cnt;
    logic [7:0] rst_cnt;
    int         err_total;
    int         compares;

    rcic_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_power_on(ev[0]),
        .i_reset_pin_b(~ev[1]), .i_wdog_expire(ev[2]), .i_timer_ovf(tovf), .i_port(port),
        .i_port_is_out(is_out), .i_bit0_is_ext(b0ext), .i_port_read(pread),
        .i_global_irq_on_instr(instr[0]), .i_global_irq_off_instr(instr[1]),
        .i_return_from_irq_instr(instr[2]), .i_sleep_instr(instr[3]),
        .i_watchdog_clear_instr(instr[4]), .i_soft_irq_instr(instr[5]), .i_vector_taken(vtaken),
        .i_reg_wr(reg_wr), .i_reg_sel_mask(sel), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_irq_flag_reg(flag), .o_irq_mask_reg(mask), .o_cpu_status_bits(stat),
        .o_core_reset(core_rst), .o_sleeping(sleeping), .o_wake(wake), .o_vector_req(vreq),
        .o_vector_addr(vaddr), .o_global_en(gie));
    rcic_core_model core (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_vector_req(vreq), .i_slow(slow),
        .o_vector_taken(vtaken));

    // ----------------------------------------
    // request, wake and reset are counted on every cycle they stand high
    // ----------------------------------------
    always @(posedge i_clk) begin
        if (vreq === 1'b1) begin
            vec_cnt  <= vec_cnt + 8'h01;
            vec_last <= vaddr;
        end
        if (wake === 1'b1) wake_cnt <= wake_cnt + 8'h01;
        if (core_rst === 1'b1) rst_cnt <= rst_cnt + 8'h01;
    end

    task automatic summarize;
        $display("compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask : cmp1

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    task automatic op(input int k);
        @(posedge i_clk);
        instr <= 6'h01 << k;
        @(posedge i_clk);
        instr <= 6'h00;
        tick(2);
    endtask : op

    task automatic wr(input logic s, input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        reg_wr <= 1'b1;
        sel    <= s;
        addr   <= a;
        wdata  <= d;
        @(posedge i_clk);
        reg_wr <= 1'b0;
        tick(2);
    endtask : wr

    task automatic rd_port;
        @(posedge i_clk);
        pread <= 1'b1;
        @(posedge i_clk);
        pread <= 1'b0;
        tick(2);
    endtask : rd_port

    task automatic rst_ev(input int k, input logic [7:0] exp);
        logic [7:0] r0;
        r0 = rst_cnt;
        @(posedge i_clk);
        ev <= 3'h1 << k;
        tick(3);
        @(posedge i_clk);
        ev <= 3'h0;
        tick(8);
        cmp1(rst_cnt != r0, 1'b1);
        cmp8(stat, exp);
        cmp8(mask, 8'h00);
    endtask : rst_ev

    task automatic t_timer;
        logic [7:0] v0;
        v0 = vec_cnt;
        @(posedge i_clk);
        tovf <= 1'b1;
        @(posedge i_clk);
        tovf <= 1'b0;
        tick(6);
        cmp8(flag, 8'h01);
        cmp8(vec_cnt, v0);
        wr(1'b0, 4'h3, 8'h00);
        cmp8(flag, 8'h01);
        wr(1'b1, 4'hF, 8'h01);
        cmp8(mask, 8'h01);
        op(0);
        tick(4);
        cmp1(vec_cnt != v0, 1'b1);
        cmp8(vec_last, 8'h08);
        cmp1(gie, 1'b0);
        wr(1'b0, 4'hF, 8'h00);
        cmp8(flag, 8'h00);
        v0 = vec_cnt;
        op(2);
        cmp1(gie, 1'b1);
        tick(4);
        cmp8(vec_cnt, v0);
        op(1);
        cmp1(gie, 1'b0);
        $display("test timer done");
    endtask : t_timer

    task automatic t_ext_soft;
        logic [7:0] v0;
        @(posedge i_clk);
        b0ext   <= 1'b1;
        port[0] <= 1'b0;
        tick(6);
        cmp8(flag, 8'h04);
        wr(1'b0, 4'hF, 8'h00);
        slow <= 1'b1;
        op(0);
        v0 = vec_cnt;
        op(5);
        tick(8);
        cmp1(vec_cnt != v0, 1'b1);
        cmp8(vec_last, 8'h01);
        cmp1(gie, 1'b0);
        $display("test ext_soft done");
    endtask : t_ext_soft

    task automatic t_change;
        logic [7:0] v0;
        wr(1'b1, 4'hF, 8'h02);
        is_out <= 8'h08;
        rd_port;
        port[3] <= ~port[3];
        tick(6);
        cmp8(flag, 8'h00);
        port[5] <= ~port[5];
        tick(6);
        cmp8(flag, 8'h02);
        wr(1'b0, 4'hF, 8'h00);
        rd_port;
        op(0);
        op(3);
        cmp1(sleeping, 1'b1);
        cmp8(stat, 8'h10);
        v0 = wake_cnt;
        port[5] <= ~port[5];
        tick(8);
        cmp8(wake_cnt, v0 + 8'h01);
        cmp1(sleeping, 1'b0);
        cmp8(stat, 8'h10);
        cmp8(vec_last, 8'h08);
        $display("test change done");
    endtask : t_change

    task automatic t_resets;
        logic [7:0] w0;
        wr(1'b1, 4'hF, 8'h07);
        op(4);
        cmp8(stat, 8'h18);
        // frozen clock enable must swallow the sleep instruction
        ce <= 1'b0;
        op(3);
        cmp8(stat, 8'h18);
        cmp1(sleeping, 1'b0);
        ce <= 1'b1;
        rst_ev(2, 8'h08);
        rst_ev(1, 8'h08);
        op(3);
        rst_ev(2, 8'h00);
        op(3);
        w0 = wake_cnt;
        rst_ev(1, 8'h10);
        cmp8(wake_cnt, w0 + 8'h01);
        rst_ev(0, 8'h18);
        $display("test resets done");
    endtask : t_resets

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    initial begin
        #40000;
        err_total++;
        summarize;
    end

    initial begin
        i_rst_b   = 1'b0;
        ce        = 1'b1;
        ev        = 3'h0;
        tovf      = 1'b0;
        port      = 8'h01;
        is_out    = 8'h00;
        b0ext     = 1'b0;
        pread     = 1'b0;
        instr     = 6'h00;
        reg_wr    = 1'b0;
        sel       = 1'b0;
        addr      = 4'hF;
        wdata     = 8'h00;
        slow      = 1'b0;
        vec_cnt   = 8'h00;
        vec_last  = 8'h00;
        wake_cnt  = 8'h00;
        rst_cnt   = 8'h00;
        err_total = 0;
        compares  = 0;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        tick(4);
        cmp8(stat, 8'h18);
        cmp8(flag, 8'h00);
        cmp8(mask, 8'h00);
        $display("test reset done");
        t_timer;
        t_ext_soft;
        t_change;
        t_resets;
        summarize;
    end
endmodule : rcic_top_tb
